// file: verilog/arcs_pkg.sv
// package: constants and types for the axi read channel slave port
package arcs_pkg;
  localparam int          ID_WIDTH_DEFAULT   = 4;
  localparam int          ADDR_WIDTH_DEFAULT = 32;
  localparam int          DATA_WIDTH_DEFAULT = 32;
  localparam int          LEN_WIDTH          = 8;
  localparam int          SIZE_WIDTH         = 3;
  localparam int          BURST_WIDTH        = 2;
  localparam int          RESP_WIDTH         = 2;
  localparam int          CACHE_WIDTH        = 5;
  localparam int          PROT_WIDTH         = 3;
  localparam logic [1:0]  BURST_FIXED        = 2'h0;
  localparam logic [1:0]  BURST_INCR         = 2'h1;
  localparam logic [1:0]  BURST_WRAP         = 2'h2;
  localparam logic [1:0]  BURST_RSVD         = 2'h3;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
  localparam logic [7:0]  LEN_RESET          = 8'h00;
  typedef enum logic [1:0] {ARCS_IDLE = 2'h0, ARCS_FETCH = 2'h1, ARCS_BEAT = 2'h3} arcs_state_t;
endpackage : arcs_pkg

// file: verilog/arcs_if.sv
// interface: axi4 read address and read data channels
`timescale 1ns/1ps
interface arcs_if #(
  parameter int ID_W   = arcs_pkg::ID_WIDTH_DEFAULT,
  parameter int ADDR_W = arcs_pkg::ADDR_WIDTH_DEFAULT,
  parameter int DATA_W = arcs_pkg::DATA_WIDTH_DEFAULT
);
  logic [ID_W-1:0]                  arid;
  logic [ADDR_W-1:0]                araddr;
  logic [arcs_pkg::LEN_WIDTH-1:0]   arlen;
  logic [arcs_pkg::SIZE_WIDTH-1:0]  arsize;
  logic [arcs_pkg::BURST_WIDTH-1:0] arburst;
  logic                             arlock;
  logic [arcs_pkg::CACHE_WIDTH-1:0] arcache;
  logic [arcs_pkg::PROT_WIDTH-1:0]  arprot;
  logic                             arvalid;
  logic                             arready;
  logic [ID_W-1:0]                  rid;
  logic [DATA_W-1:0]                rdata;
  logic [arcs_pkg::RESP_WIDTH-1:0]  rresp;
  logic                             rlast;
  logic                             rvalid;
  logic                             rready;
  modport slave (input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid, rready,
                 output arready, rid, rdata, rresp, rlast, rvalid);
  modport master (output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid, rready,
                  input arready, rid, rdata, rresp, rlast, rvalid);
endinterface : arcs_if

// file: verilog/arcs_slave.sv
// module: read channel slave end, accepts bursts and returns beats from a back end
`timescale 1ns/1ps
module arcs_slave #(
  parameter int ID_W   = arcs_pkg::ID_WIDTH_DEFAULT,
  parameter int ADDR_W = arcs_pkg::ADDR_WIDTH_DEFAULT,
  parameter int DATA_W = arcs_pkg::DATA_WIDTH_DEFAULT
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  arcs_if.slave                  AXI,
  output logic                   MEM_REQ,
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic [2:0]             MEM_SIZE,
  input  wire logic              MEM_ACK,
  input  wire logic [DATA_W-1:0] MEM_DATA,
  input  wire logic              MEM_ERR
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // widths that the stepping and the size clamp cannot serve are refused at elaboration
  if (DATA_W < 8 || DATA_W > 1024 || (DATA_W & (DATA_W - 1)) != 0)
  begin : g_bad_data_w
    $error("arcs_slave: data width must be a power of two from 8 to 1024");
  end
  if (ID_W < 1)
  begin : g_bad_id_w
    $error("arcs_slave: id width must be at least 1");
  end
  if (ADDR_W < 12)
  begin : g_bad_addr_w
    $error("arcs_slave: address width must be at least 12");
  end

  localparam int SZ_MAX = $clog2(DATA_W / 8);

  arcs_pkg::arcs_state_t state;
  logic [ID_W-1:0]   cur_id;
  logic [ADDR_W-1:0] cur_addr;
  logic [7:0]        beats_left;
  logic [7:0]        cur_len;
  logic [2:0]        cur_size;
  logic [1:0]        cur_burst;
  logic [ADDR_W-1:0] next_addr;
  logic              accept;
  logic              beat_ready;
  logic              beat_taken;

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  // wrap mask covers len+1 beats of 2**size bytes; len must be 1,3,7,15 for a true wrap
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic [2:0] sz,
                                             input logic [1:0] bt, input logic [7:0] ln);
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] msk;
    inc = ADDR_W'(1) << sz;
    msk = (ADDR_W'({4'h0, ln}) + ADDR_W'(1)) << sz;
    msk = msk - ADDR_W'(1);
    case (bt)
      arcs_pkg::BURST_FIXED: step = a;
      arcs_pkg::BURST_WRAP:  step = (a & ~msk) | ((a + inc) & msk);
      default:               step = (a & ~(inc - ADDR_W'(1))) + inc;
    endcase
  endfunction : step

  // reserved burst type is answered with an error instead of guessing
  function automatic logic [1:0] resp_code(input logic err, input logic [1:0] bt);
    if (err || bt == arcs_pkg::BURST_RSVD)
      resp_code = arcs_pkg::RESP_SLVERR;
    else
      resp_code = arcs_pkg::RESP_OKAY;
  endfunction : resp_code

  assign next_addr = step(cur_addr, cur_size, cur_burst, cur_len);

  // lock, cache and prot are never read: they cannot alter handling
  assign AXI.arready = RESETN && (state == arcs_pkg::ARCS_IDLE);
  assign MEM_REQ     = (state == arcs_pkg::ARCS_FETCH);
  assign MEM_ADDR    = cur_addr;
  assign MEM_SIZE    = cur_size;
  assign accept      = AXI.arvalid && AXI.arready;
  assign beat_ready  = (state == arcs_pkg::ARCS_FETCH) && MEM_ACK;
  assign beat_taken  = AXI.rvalid && AXI.rready;

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      state <= arcs_pkg::ARCS_IDLE;
    else
      case (state)
        arcs_pkg::ARCS_IDLE:
          if (AXI.arvalid)
            state <= arcs_pkg::ARCS_FETCH;
        arcs_pkg::ARCS_FETCH:
          if (MEM_ACK)
            state <= arcs_pkg::ARCS_BEAT;
        arcs_pkg::ARCS_BEAT:
          if (AXI.rready)
            state <= AXI.rlast ? arcs_pkg::ARCS_IDLE : arcs_pkg::ARCS_FETCH;
        default:
          state <= arcs_pkg::ARCS_IDLE;
      endcase
  end

  // ----------------------------------------
  // captured request
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      cur_id    <= '0;
      cur_len   <= arcs_pkg::LEN_RESET;
      cur_size  <= 3'h0;
      cur_burst <= arcs_pkg::BURST_INCR;
    end
    else if (accept)
    begin
      cur_id    <= AXI.arid;
      cur_len   <= AXI.arlen;
      // narrower beats only; oversize requests are clamped to the bus width
      cur_size  <= (int'(AXI.arsize) > SZ_MAX) ? 3'(SZ_MAX) : AXI.arsize;
      cur_burst <= AXI.arburst;
    end
  end

  // ----------------------------------------
  // beat address
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      cur_addr <= '0;
    else if (accept)
      cur_addr <= AXI.araddr;
    else if (beat_taken && !AXI.rlast)
      cur_addr <= next_addr;
  end

  // ----------------------------------------
  // beats still to come after the one in flight
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      beats_left <= arcs_pkg::LEN_RESET;
    else if (accept)
      beats_left <= AXI.arlen;
    else if (beat_taken && !AXI.rlast)
      beats_left <= beats_left - 8'h01;
  end

  // ----------------------------------------
  // read data channel
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      AXI.rvalid <= 1'b0;
    else if (beat_ready)
      AXI.rvalid <= 1'b1;
    else if (beat_taken)
      AXI.rvalid <= 1'b0;
  end

  // payload loads only with a fresh beat, so it stands while the master stalls
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      AXI.rdata <= '0;
      AXI.rid   <= '0;
      AXI.rresp <= arcs_pkg::RESP_OKAY;
    end
    else if (beat_ready)
    begin
      AXI.rdata <= MEM_DATA;
      AXI.rid   <= cur_id;
      AXI.rresp <= resp_code(MEM_ERR, cur_burst);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      AXI.rlast <= 1'b0;
    else if (beat_ready)
      AXI.rlast <= (beats_left == 8'h00);
    else if (beat_taken)
      AXI.rlast <= 1'b0;
  end
endmodule : arcs_slave

// file: verilog/arcs_master.sv
// module: read channel master end, issues one burst per user command
`timescale 1ns/1ps
module arcs_master #(
  parameter int ID_W   = arcs_pkg::ID_WIDTH_DEFAULT,
  parameter int ADDR_W = arcs_pkg::ADDR_WIDTH_DEFAULT,
  parameter int DATA_W = arcs_pkg::DATA_WIDTH_DEFAULT
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  arcs_if.master                 AXI,
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire logic [ID_W-1:0]   CMD_ID,
  input  wire logic [ADDR_W-1:0] CMD_ADDR,
  input  wire logic [7:0]        CMD_LEN,
  input  wire logic [2:0]        CMD_SIZE,
  input  wire logic [1:0]        CMD_BURST,
  output logic                   DATA_VALID,
  input  wire logic              DATA_READY,
  output logic [DATA_W-1:0]      DATA,
  output logic [ID_W-1:0]        DATA_ID,
  output logic [1:0]             DATA_RESP,
  output logic                   DATA_LAST
);
  logic busy;

  // ----------------------------------------
  // address channel
  // ----------------------------------------
  // one command is held unchanged until the slave takes it
  assign CMD_READY = RESETN && !busy;
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      busy        <= 1'b0;
      AXI.arvalid <= 1'b0;
      AXI.arid    <= '0;
      AXI.araddr  <= '0;
      AXI.arlen   <= arcs_pkg::LEN_RESET;
      AXI.arsize  <= 3'h0;
      AXI.arburst <= arcs_pkg::BURST_INCR;
    end
    else if (CMD_VALID && CMD_READY)
    begin
      busy        <= 1'b1;
      AXI.arvalid <= 1'b1;
      AXI.arid    <= CMD_ID;
      AXI.araddr  <= CMD_ADDR;
      AXI.arlen   <= CMD_LEN;
      AXI.arsize  <= CMD_SIZE;
      // bad wrap length or reserved type falls back to incrementing
      if (CMD_BURST == arcs_pkg::BURST_RSVD ||
          (CMD_BURST == arcs_pkg::BURST_WRAP && CMD_LEN != 8'h01 && CMD_LEN != 8'h03 &&
           CMD_LEN != 8'h07 && CMD_LEN != 8'h0F))
        AXI.arburst <= arcs_pkg::BURST_INCR;
      else
        AXI.arburst <= CMD_BURST;
    end
    else
    begin
      if (AXI.arvalid && AXI.arready)
        AXI.arvalid <= 1'b0;
      if (AXI.rvalid && AXI.rready && AXI.rlast)
        busy <= 1'b0;
    end
  end

  assign AXI.arlock  = 1'b0;
  assign AXI.arcache = '0;
  assign AXI.arprot  = '0;

  // ----------------------------------------
  // data channel, passed through to the user
  // ----------------------------------------
  assign AXI.rready = DATA_READY;
  assign DATA_VALID = AXI.rvalid;
  assign DATA       = AXI.rdata;
  assign DATA_ID    = AXI.rid;
  assign DATA_RESP  = AXI.rresp;
  assign DATA_LAST  = AXI.rlast;
endmodule : arcs_master

// file: verif/arcs_assertions.sv
// checker: handshake, id, last and reset relations on the read channels
`timescale 1ns/1ps
module arcs_assertions #(
  parameter int ID_W   = 4,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic [ID_W-1:0]   arid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [7:0]        arlen,
  input wire logic [2:0]        arsize,
  input wire logic [1:0]        arburst,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [ID_W-1:0]   rid,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rlast,
  input wire logic              rvalid,
  input wire logic              rready
);
  logic [ID_W-1:0] cap_id;
  logic [7:0]      cap_len;
  logic [7:0]      beat;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK)
  begin
    if (arvalid && arready)
    begin
      cap_id  <= arid;
      cap_len <= arlen;
    end
  end
  // beat index since acceptance
  always_ff @(posedge CLK)
  begin
    if (!RESETN || (arvalid && arready))
      beat <= 8'h00;
    else if (rvalid && rready)
      beat <= beat + 8'h01;
  end
  sequence addr_taken;
    arvalid && arready;
  endsequence
  sequence last_taken;
    rvalid && rready && rlast;
  endsequence
  busy_after_accept_a: assert property (addr_taken |=> !arready) else $error("arready high after accept");
  free_after_last_a: assert property (last_taken |=> arready) else $error("arready low after last");
  addr_hold_a: assert property (arvalid && !arready |=>
    arvalid && $stable({arid, araddr, arlen, arsize, arburst})) else $error("address changed before ready");
  beat_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable({rid, rdata, rresp, rlast})) else $error("beat changed before ready");
  id_match_a: assert property (rvalid |-> rid == cap_id) else $error("rid differs from arid");
  last_final_a: assert property (rvalid |-> rlast == (beat == cap_len)) else $error("rlast misplaced");
  no_overlap_a: assert property (rvalid |-> !arready) else $error("arready during burst");
  first_beat_a: assert property (addr_taken |-> ##[2:8] rvalid) else $error("first beat late");
  reset_zero_a: assert property (disable iff (1'b0) !RESETN |=>
    !rvalid && !rlast && rid == '0 && rdata == '0 && rresp == 2'h0) else $error("read outputs not cleared");
endmodule : arcs_assertions

// file: verif/testbench.sv
// testbench: master and slave ends joined, driven from the user and back-end sides
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready, data_valid, data_last, mem_req;
  logic [3:0]  cmd_id = 4'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic [7:0]  cmd_len = 8'h00;
  logic [1:0]  cmd_burst = 2'h1;
  logic [2:0]  cmd_size = 3'h2;
  logic        data_ready = 1'b0;
  logic        mem_ack = 1'b0;
  logic        mem_err = 1'b0;
  logic        err_mode = 1'b0;
  logic [31:0] mem_data = 32'h0;
  logic [31:0] data, mem_addr;
  logic [3:0]  data_id;
  logic [1:0]  data_resp;
  logic [2:0]  mem_size;
  int          miscompares = 0;
  int          samples_checked = 0;
  arcs_if axi ();
  always #5 clk = ~clk;
  arcs_master i_arcs_master (.CLK(clk), .RESETN(resetn), .AXI(axi.master), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_ID(cmd_id), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_SIZE(cmd_size),
    .CMD_BURST(cmd_burst), .DATA_VALID(data_valid), .DATA_READY(data_ready), .DATA(data), .DATA_ID(data_id),
    .DATA_RESP(data_resp), .DATA_LAST(data_last));
  arcs_slave i_arcs_slave (.CLK(clk), .RESETN(resetn), .AXI(axi.slave), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
    .MEM_SIZE(mem_size), .MEM_ACK(mem_ack), .MEM_DATA(mem_data), .MEM_ERR(mem_err));
  arcs_assertions i_arcs_assertions (.CLK(clk), .RESETN(resetn), .arid(axi.arid), .araddr(axi.araddr),
    .arlen(axi.arlen), .arsize(axi.arsize), .arburst(axi.arburst), .arvalid(axi.arvalid), .arready(axi.arready),
    .rid(axi.rid), .rdata(axi.rdata), .rresp(axi.rresp), .rlast(axi.rlast), .rvalid(axi.rvalid), .rready(axi.rready));
  // back end returns its own address as data; off-request data is scrambled so it cannot pass by luck
  always @(negedge clk)
  begin
    mem_ack  <= mem_req;
    mem_data <= mem_req ? mem_addr : ~mem_addr;
    mem_err  <= err_mode;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic run_burst(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
                           input logic [1:0] bt, input logic err, input logic stall, input logic [2:0] sz);
    int          k;
    int          n;
    logic [31:0] win;
    logic [31:0] base;
    logic [31:0] exp_a;
    logic [1:0]  ebt;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_id = id;
    cmd_addr = a;
    cmd_len = len;
    cmd_size = sz;
    cmd_burst = bt;
    err_mode = err;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    // a command that is never taken runs straight into the timeout below
    if (cmd_ready !== 1'b1)
      n = 2000;
    @(negedge clk);
    cmd_valid = 1'b0;
    // the master sends a reserved type or an illegal wrap length as incrementing
    ebt = bt;
    if (bt == arcs_pkg::BURST_RSVD || (bt == arcs_pkg::BURST_WRAP && !(len inside {8'h01, 8'h03, 8'h07, 8'h0F})))
      ebt = arcs_pkg::BURST_INCR;
    win = (32'(len) + 32'h1) << sz;
    base = a & ~(win - 32'h1);
    k = 0;
    // stalls on even values of n hold a beat for the ready side
    while (k <= int'(len) && n < 2000)
    begin
      data_ready = stall ? n[0] : 1'b1;
      if (data_valid === 1'b1 && data_ready)
      begin
        exp_a = (ebt == arcs_pkg::BURST_FIXED) ? a : (ebt == arcs_pkg::BURST_WRAP) ?
                base + ((a - base + (32'(k) << sz)) % win) : a + (32'(k) << sz);
        chk_word(data, exp_a);
        chk_word(32'(mem_size), 32'(sz));
        chk_word(32'(data_id), 32'(id));
        chk_word(32'(data_resp), err ? 32'h2 : 32'h0);
        chk_bit(data_last, k == int'(len));
        k++;
      end
      n++;
      @(negedge clk);
    end
    if (n >= 2000)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : run_burst
  task automatic sc_reset();
    repeat (8) @(negedge clk);
    chk_bit(axi.arready, 1'b0);
    chk_bit(axi.rvalid, 1'b0);
    chk_word(32'({axi.rid, axi.rresp, axi.rlast}), 32'h0);
    chk_word(axi.rdata, 32'h0);
    resetn = 1'b1;
    @(negedge clk);
    chk_bit(axi.arready, 1'b1);
  endtask : sc_reset
  task automatic sc_single();
    run_burst(4'h3, 32'h0000_0100, 8'h00, arcs_pkg::BURST_INCR, 1'b0, 1'b0, 3'h2);
  endtask : sc_single
  task automatic sc_longest();
    run_burst(4'hA, 32'h0000_1000, 8'hFF, arcs_pkg::BURST_INCR, 1'b0, 1'b1, 3'h2);
  endtask : sc_longest
  task automatic sc_fixed();
    run_burst(4'h5, 32'h0000_0200, 8'h03, arcs_pkg::BURST_FIXED, 1'b0, 1'b0, 3'h2);
  endtask : sc_fixed
  task automatic sc_wrap();
    run_burst(4'hC, 32'h0000_0038, 8'h03, arcs_pkg::BURST_WRAP, 1'b0, 1'b1, 3'h2);
  endtask : sc_wrap
  task automatic sc_error();
    run_burst(4'hF, 32'h0000_0300, 8'h01, arcs_pkg::BURST_INCR, 1'b1, 1'b0, 3'h2);
  endtask : sc_error
  task automatic sc_narrow();
    run_burst(4'h9, 32'h0000_0400, 8'h03, arcs_pkg::BURST_INCR, 1'b0, 1'b0, 3'h0);
    run_burst(4'h2, 32'h0000_0506, 8'h07, arcs_pkg::BURST_WRAP, 1'b0, 1'b1, 3'h1);
  endtask : sc_narrow
  task automatic sc_remap();
    run_burst(4'h6, 32'h0000_0600, 8'h02, arcs_pkg::BURST_WRAP, 1'b0, 1'b0, 3'h2);
    run_burst(4'h7, 32'h0000_0700, 8'h01, arcs_pkg::BURST_RSVD, 1'b0, 1'b0, 3'h2);
  endtask : sc_remap
  // a beat left standing when reset falls must vanish, and the port must come back idle
  task automatic sc_mid_reset();
    @(negedge clk);
    data_ready = 1'b0;
    cmd_valid = 1'b1;
    cmd_id = 4'hB;
    cmd_addr = 32'h0000_0800;
    cmd_len = 8'h07;
    cmd_size = 3'h2;
    cmd_burst = arcs_pkg::BURST_INCR;
    err_mode = 1'b0;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(data_valid, 1'b1);
    chk_word(data, 32'h0000_0800);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(axi.arready, 1'b0);
    chk_bit(axi.rvalid, 1'b0);
    chk_word(32'({axi.rid, axi.rresp, axi.rlast}), 32'h0);
    chk_word(axi.rdata, 32'h0);
    resetn = 1'b1;
    @(negedge clk);
    chk_bit(axi.arready, 1'b1);
  endtask : sc_mid_reset
  initial
  begin
    sc_reset();
    sc_single();
    sc_longest();
    sc_fixed();
    sc_wrap();
    sc_error();
    sc_narrow();
    sc_remap();
    sc_mid_reset();
    sc_single();
    report_and_stop();
  end
endmodule : testbench
